// [hw/bas_alu.sv]
`timescale 1ns/100ps
// Overview of operation
// - subtract computes file minus accumulator
// - carry and nibble flag mean no borrow
// - xor immediate writes accumulator, zero only
// - nibble exchange swaps halves, no flags
// - destination zero writes the accumulator
// - destination one writes file register back, except xor immediate
// - xor file uses destination, zero only
module bas_alu (
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              rst,
    // request from decoder and register file
    input  wire bas_pkg::bas_req_t req,
    // accumulator and status
    output logic [7:0]             acc,
    output bas_pkg::bas_flags_t    flags,
    // register file write-back
    output bas_pkg::bas_wb_t       wb,
    output logic                   done
);

    bas_pkg::bas_state_t state_r;
    bas_pkg::bas_state_t state_nxt;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic isZero(input logic [7:0] v);
        isZero = (v == 8'h00);
    endfunction

    // no borrow means minuend not below subtrahend
    function automatic logic noBorrow(input logic [7:0] f, input logic [7:0] w);
        noBorrow = (f >= w);
    endfunction

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    // result of the selected operation, before it is routed
    logic [7:0] result;
    logic [7:0] diff;

    always_comb begin
        state_nxt = state_r;
        state_nxt.wb.we = 1'b0;
        state_nxt.done = 1'b0;
        result = 8'h00;
        // formed every cycle, read only by the subtract; wraps modulo 256
        diff = req.fileData - state_r.acc;
        if (req.valid) begin
            state_nxt.done = 1'b1;
            // one code bit set is legal; any other code is refused below
            unique case (req.op)
                bas_pkg::subtract_acc_from_file: begin
                    // both flags read 1 when no borrow was needed
                    result = diff;
                    state_nxt.flags.carry = noBorrow(req.fileData, state_r.acc);
                    state_nxt.flags.nibbleBorrowFlag = noBorrow({4'h0, req.fileData[3:0]},
                                                                {4'h0, state_r.acc[3:0]});
                    state_nxt.flags.zero = isZero(result);
                end
                bas_pkg::xor_immediate_into_acc: begin
                    // carry and nibble flag keep their last subtract value
                    result = state_r.acc ^ req.immData;
                    state_nxt.flags.zero = isZero(result);
                end
                bas_pkg::nibble_exchange_op: begin
                    // flags untouched on purpose
                    result = {req.fileData[bas_pkg::NIB_LO_MSB:0],
                              req.fileData[bas_pkg::NIB_HI_MSB:bas_pkg::NIB_HI_LSB]};
                end
                bas_pkg::xor_acc_with_file: begin
                    // same flag treatment as the immediate form
                    result = state_r.acc ^ req.fileData;
                    state_nxt.flags.zero = isZero(result);
                end
                default: begin
                    // illegal code: ignore request
                    state_nxt.done = 1'b0;
                end
            endcase
            if (state_nxt.done) begin
                // immediate op always targets the accumulator
                if (req.op == bas_pkg::xor_immediate_into_acc || req.destSel == bas_pkg::DEST_ACC) begin
                    state_nxt.acc = result;
                end else begin
                    state_nxt.wb.we   = 1'b1;
                    state_nxt.wb.addr = req.fileAddr;
                    state_nxt.wb.data = result;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // only a constant in the reset branch, so the flops stay plain async-clear
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_r <= bas_pkg::STATE_RST;
        end else begin
            state_r <= state_nxt;
        end
    end

    // each output is a flop of the state record, with no logic after it
    assign acc   = state_r.acc;
    assign flags = state_r.flags;
    assign wb    = state_r.wb;
    assign done  = state_r.done;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    // decoded request kinds; only the checks below read them
    wire isSub   = req.valid && req.op == bas_pkg::subtract_acc_from_file;
    wire isXi    = req.valid && req.op == bas_pkg::xor_immediate_into_acc;
    wire isSwp   = req.valid && req.op == bas_pkg::nibble_exchange_op;
    wire isXf    = req.valid && req.op == bas_pkg::xor_acc_with_file;
    wire isLegal = isSub || isXi || isSwp || isXf;
    // valid with a code that is not one of the four one-hot values
    wire isBad   = req.valid && !isLegal;

    // the difference wraps modulo 256; a borrow out of bit 7 is dropped
    a_sub_value: assert property (@(posedge mclk) disable iff (rst)
        isSub && req.destSel |=> wb.data == $past(req.fileData) - $past(acc))
        else $error("subtract result wrong");

    // same difference into the accumulator, with no file write at all
    a_sub_acc: assert property (@(posedge mclk) disable iff (rst)
        isSub && !req.destSel |=> !wb.we && acc == $past(req.fileData) - $past(acc))
        else $error("subtract into accumulator wrong");

    // carry is the inverted borrow: set when nothing had to be borrowed
    a_sub_carry: assert property (@(posedge mclk) disable iff (rst)
        isSub |=> flags.carry == ($past(acc) <= $past(req.fileData)))
        else $error("subtract carry wrong");

    // the nibble flag compares only the low halves of the operands;
    // a wrong slice would pass any case whose low nibbles agree
    a_sub_nibble: assert property (@(posedge mclk) disable iff (rst)
        isSub |=> flags.nibbleBorrowFlag == ($past(acc[3:0]) <= $past(req.fileData[3:0])))
        else $error("nibble flag wrong");

    // carry and nibble flag move only on a subtract;
    // a stray update on an xor or a swap is easy to miss in a test
    a_flags_sub_only: assert property (@(posedge mclk) disable iff (rst)
        !isSub |=> $stable(flags.carry) && $stable(flags.nibbleBorrowFlag))
        else $error("carry changed without subtract");

    // the immediate always lands in the accumulator, whatever the select bit says
    a_xori_acc: assert property (@(posedge mclk) disable iff (rst)
        isXi |=> acc == ($past(acc) ^ $past(req.immData)) && !wb.we && $stable(flags.carry))
        else $error("xor immediate wrong");

    // zero follows the new accumulator; the nibble flag keeps its value
    a_xori_zero: assert property (@(posedge mclk) disable iff (rst)
        isXi |=> flags.zero == (acc == 8'h00) && $stable(flags.nibbleBorrowFlag))
        else $error("xor immediate flags wrong");

    // halves exchanged, flags left exactly as they were;
    // equal halves in the operand would hide a missing exchange
    a_swap_flags: assert property (@(posedge mclk) disable iff (rst)
        isSwp |=> $stable(flags) && (wb.we ? wb.data : acc) == {$past(req.fileData[3:0]), $past(req.fileData[7:4])})
        else $error("swap wrong");

    // swap into the accumulator must not touch the file register
    a_swap_acc: assert property (@(posedge mclk) disable iff (rst)
        isSwp && !req.destSel |=> !wb.we && acc == {$past(req.fileData[3:0]), $past(req.fileData[7:4])})
        else $error("swap into accumulator wrong");

    // accumulator destination must never disturb the file register;
    // the write enable is the only thing that commits a file change
    a_dest_acc: assert property (@(posedge mclk) disable iff (rst)
        req.valid && !req.destSel && !isXi |=> !wb.we)
        else $error("file written for accumulator destination");

    // file destination writes the addressed register, keeps the accumulator;
    // a refused code is left out, since it must write nothing at all
    a_dest_file: assert property (@(posedge mclk) disable iff (rst)
        (isSub || isSwp || isXf) && req.destSel |=> wb.we && wb.addr == $past(req.fileAddr) && $stable(acc))
        else $error("file write-back missing");

    // xor with the file register, wherever the result goes
    a_xorf_value: assert property (@(posedge mclk) disable iff (rst)
        isXf |=> (wb.we ? wb.data : acc) == ($past(acc) ^ $past(req.fileData)))
        else $error("xor file result wrong");

    // carry and nibble flag must survive an xor with the file
    a_xorf_flags: assert property (@(posedge mclk) disable iff (rst)
        isXf |=> $stable(flags.carry) && $stable(flags.nibbleBorrowFlag))
        else $error("xor file touched carry");

    // zero follows the byte just written, in either destination;
    // it is checked against the outputs, not against the internal result
    a_zero_flag: assert property (@(posedge mclk) disable iff (rst)
        (isSub || isXf) |=> flags.zero == ((wb.we ? wb.data : acc) == 8'h00))
        else $error("zero flag wrong");

    // a refused code leaves every output as it was: no pulse, no write;
    // without the default branch a two-hot code could half-execute
    a_bad_ignored: assert property (@(posedge mclk) disable iff (rst)
        isBad |=> !done && !wb.we && $stable(acc) && $stable(flags))
        else $error("illegal code changed state");

    // an idle cycle must not replay the last operation; the pulses
    // are cleared by default so a stale request cannot repeat
    a_idle_quiet: assert property (@(posedge mclk) disable iff (rst)
        !req.valid |=> !done && !wb.we && $stable(acc) && $stable(flags))
        else $error("idle cycle changed state");

    // main scenarios worth seeing at least once
    c_sub_file:   cover property (@(posedge mclk) disable iff (rst) isSub && req.destSel);
    c_sub_borrow: cover property (@(posedge mclk) disable iff (rst) isSub ##1 !flags.carry);
    c_xor_imm:    cover property (@(posedge mclk) disable iff (rst) isXi);
    c_swap_acc:   cover property (@(posedge mclk) disable iff (rst) isSwp && !req.destSel);
    c_zero_hit:   cover property (@(posedge mclk) disable iff (rst) isXf ##1 flags.zero);

endmodule

// [inc/bas_pkg.sv]
package bas_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int NIB_LO_MSB = 3;
    localparam int NIB_HI_LSB = 4;
    localparam int NIB_HI_MSB = 7;

    // ------------------------------------------------------------
    // reset values and destination codes
    // ------------------------------------------------------------
    localparam logic [7:0] ACC_RST     = 8'h00;
    localparam logic [6:0] ADDR_RST    = 7'h00;
    localparam logic [7:0] WB_DATA_RST = 8'h00;
    localparam logic       BIT_RST     = 1'b0;
    localparam logic       DEST_ACC  = 1'b0;
    localparam logic       DEST_FILE = 1'b1;

    // ------------------------------------------------------------
    // operation codes (one-hot)
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        subtract_acc_from_file = 4'h1,
        xor_immediate_into_acc = 4'h2,
        nibble_exchange_op     = 4'h4,
        xor_acc_with_file      = 4'h8
    } bas_op_t;

    // request from the decoder
    typedef struct packed {
        logic       valid;
        bas_op_t    op;
        logic [6:0] fileAddr;
        logic       destSel;
        logic [7:0] fileData;
        logic [7:0] immData;
    } bas_req_t;

    // status flags
    typedef struct packed {
        logic carry;
        logic nibbleBorrowFlag;
        logic zero;
    } bas_flags_t;

    // write-back to the register file
    typedef struct packed {
        logic       we;
        logic [6:0] addr;
        logic [7:0] data;
    } bas_wb_t;

    // whole module state
    typedef struct packed {
        logic [7:0] acc;
        bas_flags_t flags;
        bas_wb_t    wb;
        logic       done;
    } bas_state_t;

    // ------------------------------------------------------------
    // reset values of the records
    // ------------------------------------------------------------
    localparam bas_flags_t FLAGS_RST = '{carry: BIT_RST, nibbleBorrowFlag: BIT_RST, zero: BIT_RST};
    localparam bas_state_t STATE_RST = '{
        acc:   ACC_RST,
        flags: FLAGS_RST,
        wb:    '{we: BIT_RST, addr: ADDR_RST, data: WB_DATA_RST},
        done:  BIT_RST
    };

endpackage

// [tb/bas_regfile_model.sv]
`timescale 1ns/100ps
module bas_regfile_model (
    // clock
    input  wire logic             mclk,
    // address and write-back
    input  wire logic [6:0]       addr,
    input  wire bas_pkg::bas_wb_t wb,
    // read data
    output logic [7:0]            rdata
);
    logic [7:0] mem [128];
    // a pattern, so no read ever returns unknown
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = 8'(i * 37 + 5);
        end
    end
    // writes land on the edge, reads follow the address at once
    always @(posedge mclk) begin
        if (wb.we) begin
            mem[wb.addr] <= wb.data;
        end
    end
    assign rdata = mem[addr];
endmodule

// [tb/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
    localparam bas_pkg::bas_op_t SUB = bas_pkg::subtract_acc_from_file;
    localparam bas_pkg::bas_op_t XIM = bas_pkg::xor_immediate_into_acc;
    localparam bas_pkg::bas_op_t SWP = bas_pkg::nibble_exchange_op;
    localparam bas_pkg::bas_op_t XWF = bas_pkg::xor_acc_with_file;
    logic mclk, rst, done;
    logic [7:0] acc, rdata, accE;
    bas_pkg::bas_req_t drv, req;
    bas_pkg::bas_flags_t flags, flE;
    bas_pkg::bas_wb_t wb;
    int n_mismatch, checks, cyc;
    // file data follows the address within the cycle
    always_comb begin
        req = drv;
        req.fileData = rdata;
    end
    bas_alu dut (.mclk(mclk), .rst(rst), .req(req), .acc(acc), .flags(flags), .wb(wb), .done(done));
    bas_regfile_model pm (.mclk(mclk), .addr(drv.fileAddr), .wb(wb), .rdata(rdata));
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // hang guard, far above the few dozen cycles the run needs
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 400) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one op, expectation worked out first, then outputs one cycle on
    task automatic run(input bas_pkg::bas_op_t op, input logic [6:0] a, input logic d, input logic [7:0] k);
        logic [7:0] f, r;
        logic wr;
        f = pm.mem[a];
        case (op)
            SUB: begin
                r = f - accE;
                flE.carry = accE <= f;
                flE.nibbleBorrowFlag = accE[3:0] <= f[3:0];
            end
            XIM: r = accE ^ k;
            SWP: r = {f[3:0], f[7:4]};
            default: r = accE ^ f;
        endcase
        if (op != SWP) flE.zero = (r == 8'h00);
        wr = d && op != XIM;
        if (!wr) accE = r;
        drv = '{1'b1, op, a, d, 8'h00, k};
        @(posedge mclk) #1;
        drv.valid = 1'b0;
        chk("done", 8'h01, {7'h0, done});
        chk("acc", accE, acc);
        chk("flags", 8'(flE), 8'(flags));
        chk("wb.we", {7'h0, wr}, {7'h0, wb.we});
        if (wr) chk("wb.data", r, wb.data);
        if (wr) chk("wb.addr", {1'b0, a}, {1'b0, wb.addr});
        @(posedge mclk) #1;
        chk("done low", 8'h00, {7'h0, done});
        chk("file", wr ? r : f, pm.mem[a]);
    endtask
    task automatic load(input logic [7:0] v);
        run(XIM, 7'h00, 1'b1, accE ^ v);
    endtask
    task automatic t_sub();
        load(pm.mem[7'h05]);
        run(SUB, 7'h05, 1'b1, 8'h00);
        load(pm.mem[7'h7F] + 8'h01);
        run(SUB, 7'h7F, 1'b0, 8'h00);
        load(8'h0F);
        run(SUB, 7'h40, 1'b1, 8'h00);
    endtask
    task automatic t_other();
        run(SWP, 7'h0B, 1'b0, 8'h00);
        run(SWP, 7'h7F, 1'b1, 8'h00);
        load(pm.mem[7'h14]);
        run(XWF, 7'h14, 1'b1, 8'h00);
        run(XWF, 7'h15, 1'b0, 8'h00);
        load(8'h00);
    endtask
    // an op code with two bits set must be ignored
    task automatic t_bad();
        drv = '{1'b1, bas_pkg::bas_op_t'(4'h3), 7'h01, 1'b0, 8'h00, 8'hFF};
        @(posedge mclk) #1;
        chk("done bad", 8'h00, {7'h0, done});
        chk("acc bad", accE, acc);
        chk("flags bad", 8'(flE), 8'(flags));
        // back to back: a two-hot code with the file destination writes nothing
        drv = '{1'b1, bas_pkg::bas_op_t'(4'hC), 7'h01, 1'b1, 8'h00, 8'h00};
        @(posedge mclk) #1;
        drv.valid = 1'b0;
        chk("done bad2", 8'h00, {7'h0, done});
        chk("wb.we bad2", 8'h00, {7'h0, wb.we});
        chk("acc bad2", accE, acc);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        drv = '0;
        accE = bas_pkg::ACC_RST;
        flE = bas_pkg::FLAGS_RST;
        repeat (20) @(posedge mclk);
        #1 rst = 1'b0;
        chk("acc rst", bas_pkg::ACC_RST, acc);
        chk("flags rst", 8'(bas_pkg::FLAGS_RST), 8'(flags));
        t_sub();
        t_other();
        t_bad();
        tally_and_finish();
    end
endmodule
